// *** verification/seq_master_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ********************************
// Sequencer side bus master
// ********************************
module seq_master_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  output var  logic        psel,
  output var  logic        penable,
  output var  logic        pwrite,
  output var  logic [11:0] paddr,
  output var  logic [31:0] pwdata
);
  logic hang;

  initial
  begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h00000000;
    hang    = 1'b0;
  end

  // One command word per activation
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 16)
    begin
      n++;
      @(posedge pclk);
    end
    if (n == 16)
      hang = 1'b1;
    rd      = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~wd;
    // Let one edge pass so that a following call does not assign psel twice in one time step
    @(posedge pclk);
  endtask
endmodule // seq_master_model

`default_nettype wire

// *** verification/tb_top.sv ***
`include "acc_unit_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  logic                 pclk;
  logic                 presetn;
  logic                 psel;
  logic                 penable;
  logic                 pwrite;
  logic [11:0]          paddr;
  logic [31:0]          pwdata;
  logic                 pready;
  logic [31:0]          prdata;
  logic                 pslverr;
  acc_unit_pkg::flags_s flags;
  int                   errors;
  int                   comparisons;
  logic [9:0]           ef;
  logic [31:0]          rd;
  logic                 err;
  logic [31:0]          ca [3] = '{32'h0000FFFF, 32'hFFFFFFFF, 32'h80000000};
  logic [31:0]          ra [6] = '{32'h00800000, 32'h7F800000, 32'h40000000,
                                   32'h40000000, 32'hC0C00000, 32'h40C00000};
  logic [31:0]          rb [6] = '{32'h40800000, 32'h40000000, 32'h7F800000,
                                   32'h00000000, 32'h40000000, 32'h40000000};
  logic [31:0]          rq [6] = '{32'h00000000, 32'h7F800000, 32'h40000000,
                                   32'h40000000, 32'hC0400000, 32'h40400000};
  logic [9:0]           rm [6] = '{10'h100, 10'h040, 10'h200, 10'h001, 10'h3D3, 10'h3D3};
  logic [9:0]           rv [6] = '{10'h100, 10'h040, 10'h200, 10'h001, 10'h010, 10'h000};
  acc_unit_pkg::op_e    ops [3] = '{acc_unit_pkg::binary_add_word, acc_unit_pkg::binary_add_double,
                                    acc_unit_pkg::binary_subtract_word};
  acc_unit_pkg::src_e   srcs [3] = '{acc_unit_pkg::src_direct, acc_unit_pkg::src_const,
                                     acc_unit_pkg::src_const};

  accumulator_arith_flags_unit u_accumulator_arith_flags_unit (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .flags(flags)
  );

  seq_master_model u_seq_master_model (
    .pclk(pclk), .pready(pready), .prdata(prdata), .pslverr(pslverr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata)
  );

  initial
  begin
    pclk = 1'b0;
  end

  always #20 pclk = ~pclk;

  // ********************************
  // Helpers
  // ********************************
  task automatic complete_run();
    if (u_seq_master_model.hang)
      errors++;
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    u_seq_master_model.xfer(1'b1, a, d, rd, err);
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] e);
    u_seq_master_model.xfer(1'b0, a, 32'h00000000, rd, err);
    check(rd, e);
  endtask

  task automatic mem(input logic [7:0] i, input logic [31:0] v);
    wr({2'b01, i, 2'b00}, v);
  endtask

  task automatic exec(input acc_unit_pkg::op_e op, input acc_unit_pkg::src_e src,
                      input logic [9:0] m, input logic [9:0] v, input logic [9:0] cm);
    wr(`REG_CTRL, {26'h0, src, 1'b0, op});
    @(posedge pclk);
    ef = (ef & ~m) | (v & m);
    u_seq_master_model.xfer(1'b0, `REG_FLAGS, 32'h00000000, rd, err);
    check(rd & {22'h0, cm}, {22'h0, ef & cm});
    check({22'h0, flags} & {22'h0, cm}, {22'h0, ef & cm});
  endtask

  function automatic logic [31:0] to_bcd(input int unsigned v);
    logic [31:0] b;
    for (int i = 0; i < 8; i++)
    begin
      b[i*4+:4] = 4'(v % 10);
      v = v / 10;
    end
    return b;
  endfunction

  // ********************************
  // Tests
  // ********************************
  initial
  begin
    logic [31:0] a;
    logic [31:0] w;
    logic [31:0] b;
    logic [32:0] s;
    logic [16:0] c;
    logic        sg;
    int unsigned x;
    int unsigned d;
    errors      = 0;
    comparisons = 0;
    ef          = `FLAGS_RST;
    presetn     = 1'b0;
    void'($urandom(35));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`REG_ACC, `ACC_RST);
    rdc(`REG_STACK, `STACK_RST);
    rdc(`REG_FLAGS, {22'h0, `FLAGS_RST});
    rdc(12'h020, 32'h00000000);
    check({31'h0, err}, 32'h00000001);
    for (int k = 0; k < 9; k++)
    begin
      a  = (k < 3) ? ca[k] : $urandom;
      w  = (k < 3) ? 32'h00000001 : $urandom;
      b  = (k % 3 == 1) ? w : {16'h0, w[15:0]};
      s  = (k % 3 == 2) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, b};
      c  = {1'b0, a[15:0]} + {1'b0, b[15:0]};
      sg = (k % 3 == 2) ? a[31] & ~s[31] : ~(a[31] ^ b[31]) & (s[31] ^ a[31]);
      wr(`REG_ACC, a);
      mem(8'h10, {16'h0, w[15:0]});
      wr(`REG_OPERAND, (k % 3 == 0) ? 32'h00000010 : b);
      exec(ops[k % 3], srcs[k % 3], (k % 3 == 2) ? 10'h092 : 10'h09E,
           {2'b00, sg, 2'b00, s[31], s[32], c[16], s[31:0] == 32'h0, 1'b0}, 10'h3FF);
      rdc(`REG_ACC, s[31:0]);
    end
    for (int k = 0; k < 4; k++)
    begin
      x = (k < 2) ? 9999 * (1 - k) : $urandom % 10000;
      d = (k % 2 == 0) ? (x + 1) % 10000 : (x + 9999) % 10000;
      w = to_bcd(x);
      mem(8'h20, {16'h0, w[15:0]});
      wr(`REG_OPERAND, 32'h00000020);
      exec((k % 2 == 0) ? acc_unit_pkg::bcd_increment_op : acc_unit_pkg::bcd_decrement_op,
           acc_unit_pkg::src_direct, 10'h202, {8'h00, d == 0, 1'b0}, 10'h3FF);
      w = to_bcd(d);
      rdc(12'h480, {16'h0, w[15:0]});
    end
    x = $urandom % 90000000 + 10000;
    d = $urandom % 9999 + 1;
    w = to_bcd(d);
    wr(`REG_ACC, to_bcd(x));
    mem(8'h30, {16'h0, w[15:0]});
    mem(8'h31, {16'h0, w[31:16]});
    wr(`REG_OPERAND, 32'h00000030);
    exec(acc_unit_pkg::bcd_divide_double, acc_unit_pkg::src_direct,
         10'h213, 10'h000, 10'h3FF);
    rdc(`REG_ACC, to_bcd(x / d));
    rdc(`REG_STACK, to_bcd(x % d));
    exec(acc_unit_pkg::bcd_divide_double, acc_unit_pkg::src_const,
         10'h000, 10'h000, 10'h3FF);
    rdc(`REG_ACC, to_bcd(x / d));
    rdc(`REG_STATUS, 32'h00000002);
    mem(8'h30, 32'h00000000);
    mem(8'h31, 32'h00000000);
    exec(acc_unit_pkg::bcd_divide_double, acc_unit_pkg::src_direct,
         10'h001, 10'h001, 10'h001);
    rdc(`REG_ACC, to_bcd(x / d));
    rdc(`REG_STACK, to_bcd(x % d));
    mem(8'h20, 32'h000012A4);
    wr(`REG_OPERAND, 32'h00000020);
    exec(acc_unit_pkg::bcd_increment_op, acc_unit_pkg::src_direct,
         10'h200, 10'h200, 10'h200);
    rdc(12'h480, 32'h000012A4);
    for (int k = 0; k < 6; k++)
    begin
      wr(`REG_ACC, ra[k]);
      wr(`REG_OPERAND, rb[k]);
      exec(acc_unit_pkg::real_divide, acc_unit_pkg::src_const, rm[k], rv[k],
           (k < 4) ? rm[k] : 10'h3FF);
      rdc(`REG_ACC, rq[k]);
    end
    mem(8'h40, 32'h00000100);
    wr(`REG_OPERAND, 32'h00000040);
    exec(acc_unit_pkg::real_divide, acc_unit_pkg::src_pointer,
         10'h020, 10'h020, 10'h3FF);
    rdc(`REG_ACC, 32'h40400000);
    mem(8'h40, 32'h00000050);
    mem(8'h50, 32'h00000000);
    mem(8'h51, 32'h00004000);
    wr(`REG_ACC, 32'h40C00000);
    exec(acc_unit_pkg::real_divide, acc_unit_pkg::src_pointer,
         10'h3F3, 10'h000, 10'h3FF);
    rdc(`REG_ACC, 32'h40400000);
    complete_run();
  end

  initial
  begin
    repeat (20000) @(posedge pclk);
    errors++;
    complete_run();
  end
endmodule // tb_top

`default_nettype wire

// *** verilog/acc_unit_pkg.sv ***
package acc_unit_pkg;

  typedef enum logic [2:0] {
    op_nop               = 3'h0,
    bcd_divide_double    = 3'h1,
    real_divide          = 3'h2,
    bcd_increment_op     = 3'h3,
    bcd_decrement_op     = 3'h4,
    binary_add_word      = 3'h5,
    binary_add_double    = 3'h6,
    binary_subtract_word = 3'h7
  } op_e;

  typedef enum logic [1:0] {
    src_direct  = 2'h0,
    src_pointer = 2'h1,
    src_const   = 2'h2,
    src_illegal = 2'h3
  } src_e;

  typedef enum logic {
    st_idle = 1'b0,
    st_exec = 1'b1
  } state_e;

  typedef struct packed {
    logic bad_operand_format_flag;
    logic underflow_flag;
    logic sign_error_flag;
    logic invalid_real_flag;
    logic bad_pointer_flag;
    logic negative_flag;
    logic carry32_flag;
    logic carry16_flag;
    logic zero_result_flag;
    logic operand_range_flag;
  } flags_s;

  typedef struct packed {
    op_e  op;
    src_e src;
  } cmd_s;

endpackage

// *** verilog/acc_unit_regs.svh ***
`ifndef ACC_UNIT_REGS_SVH
`define ACC_UNIT_REGS_SVH

// ****************************************
// Register byte offsets
// ****************************************
`define REG_CTRL     12'h000
`define REG_OPERAND  12'h004
`define REG_ACC      12'h008
`define REG_STACK    12'h00C
`define REG_FLAGS    12'h010
`define REG_STATUS   12'h014
`define MEM_SEL      2'h1

// ****************************************
// Field positions
// ****************************************
`define CTRL_OP_LSB  0
`define CTRL_SRC_LSB 4
`define MEM_IDX_LSB  2
`define MEM_SEL_LSB  10

// ****************************************
// Reset values and sizes
// ****************************************
`define ACC_RST      32'h00000000
`define STACK_RST    32'h00000000
`define OPERAND_RST  32'h00000000
`define FLAGS_RST    10'h000
`define MEM_WORDS    256
`define BCD4_MAX     27'd9999
`define REAL_EXP_MAX 8'hFF
`define REAL_BIAS    11'sd127

`endif

// *** verilog/accumulator_arith_flags_unit.sv ***
`include "acc_unit_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module accumulator_arith_flags_unit #(
  parameter int MEM_WORDS = `MEM_WORDS
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output var  logic                 pready,
  output var  logic [31:0]          prdata,
  output var  logic                 pslverr,
  output var  acc_unit_pkg::flags_s flags
);

  // ****************************************
  // Helper functions
  // ****************************************
  function automatic logic bcd_ok(input logic [31:0] v);
    logic ok;
    ok = 1'b1;
    for (int i = 0; i < 8; i++)
    begin
      if (v[i*4 +: 4] > 4'h9)
        ok = 1'b0;
    end
    return ok;
  endfunction

  function automatic logic [26:0] bcd_to_bin(input logic [31:0] v);
    logic [26:0] r;
    r = 27'h0;
    for (int i = 7; i >= 0; i--)
      r = 27'(r * 27'd10) + 27'(v[i*4 +: 4]);
    return r;
  endfunction

  function automatic logic [31:0] bin_to_bcd(input logic [26:0] v);
    logic [31:0] r;
    logic [26:0] t;
    r = 32'h0;
    t = v;
    for (int i = 0; i < 8; i++)
    begin
      r[i*4 +: 4] = 4'(t % 27'd10);
      t = t / 27'd10;
    end
    return r;
  endfunction

  // Result bits 33 overflow, 32 underflow, 31:0 value
  function automatic logic [33:0] real_div(input logic [31:0] a, input logic [31:0] b);
    logic        s;
    logic [48:0] q;
    logic [22:0] f;
    logic signed [10:0] e;
    s = a[31] ^ b[31];
    q = {1'b1, a[22:0], 25'h0} / {25'h0, 1'b1, b[22:0]};
    e = $signed({3'h0, a[30:23]}) - $signed({3'h0, b[30:23]}) + `REAL_BIAS;
    if (q[25])
      f = q[24:2];
    else
    begin
      f = q[23:1];
      e = e - 11'sd1;
    end
    if (a[30:23] == 8'h00)
      return {2'h0, s, 31'h0};
    if (e <= 11'sd0)
      return {2'h1, s, 31'h0};
    if (e >= 11'sd255)
      return {2'h2, s, `REAL_EXP_MAX, 23'h0};
    return {2'h0, s, e[7:0], f};
  endfunction

  // ****************************************
  // State
  // ****************************************
  logic [15:0]          mem [0:MEM_WORDS-1];
  acc_unit_pkg::state_e state;
  acc_unit_pkg::cmd_s   cmd;
  logic [31:0]          operand;
  logic [31:0]          acc;
  logic [31:0]          stack;
  logic                 refused;

  // ****************************************
  // Bus decode
  // ****************************************
  wire        setup    = psel & ~penable;
  wire        wr       = psel & penable & pready & pwrite;
  wire        idle     = state == acc_unit_pkg::st_idle;
  wire        mem_hit  = paddr[11:`MEM_SEL_LSB] == `MEM_SEL;
  wire [7:0]  midx     = paddr[9:`MEM_IDX_LSB];
  wire        hit_ctrl = paddr == `REG_CTRL;
  wire        hit_opnd = paddr == `REG_OPERAND;
  wire        hit_acc  = paddr == `REG_ACC;
  wire        hit_stk  = paddr == `REG_STACK;
  wire        hit_flg  = paddr == `REG_FLAGS;
  wire        hit_sts  = paddr == `REG_STATUS;
  wire        hit_any  = mem_hit | hit_ctrl | hit_opnd | hit_acc | hit_stk | hit_flg | hit_sts;
  wire [31:0] rd_value = mem_hit  ? {16'h0, mem[midx]} :
                         hit_ctrl ? {26'h0, cmd.src, 1'b0, cmd.op} :
                         hit_opnd ? operand :
                         hit_acc  ? acc :
                         hit_stk  ? stack :
                         hit_flg  ? {22'h0, flags} :
                         hit_sts  ? {30'h0, refused, ~idle} : 32'h0;

  // ****************************************
  // Operand fetch
  // ****************************************
  wire        is_ptr   = cmd.src == acc_unit_pkg::src_pointer;
  wire        is_const = cmd.src == acc_unit_pkg::src_const;
  wire        dbl      = cmd.op == acc_unit_pkg::bcd_divide_double ||
                         cmd.op == acc_unit_pkg::real_divide ||
                         cmd.op == acc_unit_pkg::binary_add_double;
  wire        bcd_op   = cmd.op == acc_unit_pkg::bcd_divide_double ||
                         cmd.op == acc_unit_pkg::bcd_increment_op ||
                         cmd.op == acc_unit_pkg::bcd_decrement_op;
  wire [15:0] ea       = is_ptr ? mem[operand[7:0]] : {8'h0, operand[7:0]};
  wire [16:0] ea_last  = {1'b0, ea} + (dbl ? 17'h1 : 17'h0);
  wire        ptr_bad  = is_ptr && ea_last >= 17'(MEM_WORDS);
  wire [7:0]  ia       = ea[7:0];
  wire [7:0]  ib       = ia + 8'h01;
  wire [15:0] word_lo  = is_const ? operand[15:0] : mem[ia];
  wire [31:0] word32   = is_const ? operand : {mem[ib], mem[ia]};
  wire        refuse   = cmd.op == acc_unit_pkg::op_nop ||
                         cmd.src == acc_unit_pkg::src_illegal ||
                         (bcd_op && is_const);
  wire        exec     = ~idle & ~refuse & ~ptr_bad;

  // ****************************************
  // Datapaths
  // ****************************************
  wire [26:0] a_bin    = bcd_to_bin(acc);
  wire [26:0] d_bin    = bcd_to_bin(word32);
  wire        d_zero   = d_bin == 27'h0;
  wire [26:0] q_bin    = d_zero ? 27'h0 : a_bin / d_bin;
  wire [26:0] r_bin    = d_zero ? 27'h0 : a_bin % d_bin;
  wire        div_fmt  = bcd_ok(acc) & bcd_ok(word32);
  wire [26:0] w_bin    = bcd_to_bin({16'h0, word_lo});
  wire        w_fmt    = bcd_ok({16'h0, word_lo});
  wire [26:0] inc_bin  = w_bin == `BCD4_MAX ? 27'h0 : w_bin + 27'h1;
  wire [26:0] dcr_bin  = w_bin == 27'h0 ? `BCD4_MAX : w_bin - 27'h1;
  wire [31:0] inc_bcd  = bin_to_bcd(inc_bin);
  wire [31:0] dcr_bcd  = bin_to_bcd(dcr_bin);
  wire        acc_nan  = acc[30:23] == `REAL_EXP_MAX;
  wire        opr_nan  = word32[30:23] == `REAL_EXP_MAX;
  wire        opr_zero = word32[30:23] == 8'h00;
  wire [33:0] rdiv     = real_div(acc, word32);
  wire [31:0] add_op   = dbl ? word32 : {16'h0, word_lo};
  wire [32:0] add_sum  = {1'b0, acc} + {1'b0, add_op};
  wire [16:0] lo_sum   = {1'b0, acc[15:0]} + {1'b0, add_op[15:0]};
  wire        add_ovf  = acc[31] == add_op[31] && add_sum[31] != acc[31];
  wire [31:0] sub_diff = acc - {16'h0, word_lo};
  wire        sub_ovf  = acc[31] && !sub_diff[31];

  // ****************************************
  // Execution
  // ****************************************
  logic [31:0]          next_acc;
  logic [31:0]          next_stack;
  acc_unit_pkg::flags_s next_flags;
  logic                 mem_we;
  logic [15:0]          mem_wdata;

  always_comb
  begin
    next_acc   = acc;
    next_stack = stack;
    next_flags = flags;
    mem_we     = 1'b0;
    mem_wdata  = 16'h0;
    if (~idle && ~refuse)
    begin
      if (is_ptr)
        next_flags.bad_pointer_flag = ptr_bad;
      if (~ptr_bad)
      begin
        unique case (cmd.op)
          acc_unit_pkg::op_nop:
          begin
          end
          acc_unit_pkg::bcd_divide_double:
          begin
            next_flags.bad_operand_format_flag = ~div_fmt;
            next_flags.operand_range_flag = d_zero || d_bin > a_bin;
            if (div_fmt && !d_zero)
            begin
              next_acc   = bin_to_bcd(q_bin);
              next_stack = bin_to_bcd(r_bin);
              next_flags.zero_result_flag = q_bin == 27'h0;
              next_flags.negative_flag    = 1'b0;
            end
          end
          acc_unit_pkg::real_divide:
          begin
            next_flags.invalid_real_flag       = acc_nan;
            next_flags.bad_operand_format_flag = opr_nan;
            next_flags.operand_range_flag      = opr_zero;
            next_flags.sign_error_flag         = 1'b0;
            if (!acc_nan && !opr_nan && !opr_zero)
            begin
              next_acc = rdiv[31:0];
              next_flags.underflow_flag    = rdiv[32];
              next_flags.invalid_real_flag = rdiv[33];
              next_flags.zero_result_flag  = rdiv[30:0] == 31'h0;
              next_flags.negative_flag     = rdiv[31];
            end
          end
          acc_unit_pkg::bcd_increment_op:
          begin
            next_flags.bad_operand_format_flag = ~w_fmt;
            if (w_fmt)
            begin
              mem_we    = 1'b1;
              mem_wdata = inc_bcd[15:0];
              next_flags.zero_result_flag = inc_bin == 27'h0;
            end
          end
          acc_unit_pkg::bcd_decrement_op:
          begin
            next_flags.bad_operand_format_flag = ~w_fmt;
            if (w_fmt)
            begin
              mem_we    = 1'b1;
              mem_wdata = dcr_bcd[15:0];
              next_flags.zero_result_flag = dcr_bin == 27'h0;
            end
          end
          acc_unit_pkg::binary_add_word,
          acc_unit_pkg::binary_add_double:
          begin
            next_acc = add_sum[31:0];
            next_flags.carry16_flag     = lo_sum[16];
            next_flags.carry32_flag     = add_sum[32];
            next_flags.sign_error_flag  = add_ovf;
            next_flags.zero_result_flag = add_sum[31:0] == 32'h0;
            next_flags.negative_flag    = add_sum[31];
          end
          acc_unit_pkg::binary_subtract_word:
          begin
            next_acc = sub_diff;
            next_flags.sign_error_flag  = sub_ovf;
            next_flags.zero_result_flag = sub_diff == 32'h0;
            next_flags.negative_flag    = sub_diff[31];
          end
        endcase
      end
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready  <= setup;
      prdata  <= setup ? rd_value : prdata;
      pslverr <= setup & ~hit_any;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state   <= acc_unit_pkg::st_idle;
      cmd     <= '{acc_unit_pkg::op_nop, acc_unit_pkg::src_direct};
      operand <= `OPERAND_RST;
      acc     <= `ACC_RST;
      stack   <= `STACK_RST;
      flags   <= `FLAGS_RST;
      refused <= 1'b0;
    end
    else if (!idle)
    begin
      state   <= acc_unit_pkg::st_idle;
      acc     <= next_acc;
      stack   <= next_stack;
      flags   <= next_flags;
      refused <= refuse;
    end
    else if (wr)
    begin
      if (hit_ctrl)
      begin
        cmd.op  <= acc_unit_pkg::op_e'(pwdata[`CTRL_OP_LSB +: 3]);
        cmd.src <= acc_unit_pkg::src_e'(pwdata[`CTRL_SRC_LSB +: 2]);
        state   <= acc_unit_pkg::st_exec;
      end
      if (hit_opnd)
        operand <= pwdata;
      if (hit_acc)
        acc <= pwdata;
      if (hit_stk)
        stack <= pwdata;
    end
  end

  always_ff @(posedge pclk)
  begin
    if (mem_we)
      mem[ia] <= mem_wdata;
    else if (idle && wr && mem_hit)
      mem[midx] <= pwdata[15:0];
  end

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  wire run_div = exec && cmd.op == acc_unit_pkg::bcd_divide_double;
  wire run_addw = exec && cmd.op == acc_unit_pkg::binary_add_word;
  wire run_sub = exec && cmd.op == acc_unit_pkg::binary_subtract_word;

  AST_CONST_DIVISOR: assert property (
    (~idle && bcd_op && is_const) |=> acc == $past(acc) && stack == $past(stack) && refused)
    else $error("constant divisor changed accumulator");

  AST_ZERO_DIVISOR: assert property (
    (run_div && d_zero) |=> flags.operand_range_flag && acc == $past(acc))
    else $error("zero divisor not flagged or accumulator changed");

  AST_DIV_RESULT: assert property (
    (run_div && div_fmt && !d_zero && acc == 32'h00000007 && word32 == 32'h00000002)
    |=> acc == 32'h00000003 && stack == 32'h00000001)
    else $error("BCD divide result wrong");

  AST_BCD_BAD: assert property (
    (run_div && acc[3:0] == 4'hA) |=> flags.bad_operand_format_flag && acc == $past(acc))
    else $error("non-BCD digit not flagged");

  AST_ADD_SUM: assert property (
    run_addw |=> acc == $past(acc) + {16'h0, $past(word_lo)})
    else $error("word add result wrong");

  AST_CARRY16: assert property (
    run_addw |=> flags.carry16_flag == ({1'b0, $past(acc[15:0])} + {1'b0, $past(word_lo)} > 17'hFFFF))
    else $error("carry16 wrong");

  AST_SUB_FLAGS: assert property (
    run_sub |=> flags.zero_result_flag == (acc == 32'h0) && flags.negative_flag == acc[31])
    else $error("zero or negative flag wrong");

  AST_FLAG_HOLD: assert property (
    (exec && cmd.op == acc_unit_pkg::bcd_increment_op) |=> $stable(flags.carry16_flag) && $stable(acc))
    else $error("unrelated flag changed");

  AST_BAD_POINTER: assert property (
    (~idle && ~refuse && ptr_bad) |=> flags.bad_pointer_flag && $stable(acc))
    else $error("bad pointer not flagged");

  AST_APB_ANSWER: assert property (
    (setup ##1 psel && penable) |-> pready)
    else $error("access phase without ready");

  COV_DIVIDE: cover property (run_div && div_fmt && !d_zero);
  COV_REAL: cover property (exec && cmd.op == acc_unit_pkg::real_divide && rdiv[32]);
  COV_CARRY: cover property (run_addw && lo_sum[16]);
  COV_INCREMENT: cover property (exec && cmd.op == acc_unit_pkg::bcd_increment_op && w_fmt);

endmodule // accumulator_arith_flags_unit

`default_nettype wire
